// File: core/adc_ch6_ch7_calib_config_regs.sv
// module: channel 6/7 calibration and channel 7 setup register bank
`timescale 1ns/100ps

// Summary of operation
// - channel 6 offset low register keeps offset bits 7:0 in its upper byte.
// - channel 7 offset high register keeps bits 23:8; whole word is signed.
// - channel 6 gain high register keeps gain bits 23:8, unsigned below two.
// - both gain high registers reset to 8000h, giving unity gain.
// - channel 6 gain low register keeps gain bits 7:0 in its upper byte.
// - lower byte of each low trim register reads zero always.
// - channel 7 setup bits 15:6 are a signed ten-bit phase delay.
// - channel 7 setup bits 5:3 read zero always.
// - setup bit 2 set disables channel 7 dc removal, else global setting.
// - setup bits 1:0 choose pins, shorted, positive or negative test signal.
// - channel 7 setup register resets to zero.
// - channel 7 offset high register resets to zero.
// - channel 6 gain low register resets to zero.
module adc_ch6_ch7_calib_config_regs (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	// register access from the serial port
	input wire calib_regs_pkg::reg_req_s I_REQ,
	output logic [15:0] O_RDATA,
	output logic O_ADDR_HIT,
	// global dc removal setting for channel 7
	input wire logic I_GLOBAL_DC_REMOVAL_SETTING,
	// calibration words to the datapath
	output logic [23:0] O_CH6_OFFSET_LOW_BYTE_WORD,
	output logic [23:0] O_CH6_GAIN,
	output logic signed [23:0] O_CH7_OFFSET,
	output logic [23:0] O_CH7_GAIN_UPPER,
	// channel 7 setup to the datapath
	output calib_regs_pkg::ch_setup_s O_CH7_SETUP,
	output logic O_CH7_DC_REMOVAL_EN
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] ch6_gain_upper_word_q;
	logic [15:0] ch6_gain_upper_word_d;
	logic [15:0] ch7_setup_q;
	logic [15:0] ch7_setup_d;
	logic [15:0] ch7_offset_upper_word_q;
	logic [15:0] ch7_offset_upper_word_d;
	logic [15:0] ch7_gain_upper_word_q;
	logic [15:0] ch7_gain_upper_word_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic hit_q;
	logic hit_d;
	logic [2:0] low_wr;
	logic [15:0] low_rdata [3];
	logic [7:0] low_byte [3];
	logic [5:0] low_addr [3];

	// low-byte register addresses, indexed by entry
	assign low_addr[0] = calib_regs_pkg::CH6_OFFSET_TRIM_LOW_ADDR;
	assign low_addr[1] = calib_regs_pkg::CH6_GAIN_TRIM_LOW_ADDR;
	assign low_addr[2] = calib_regs_pkg::CH7_OFFSET_TRIM_LOW_ADDR;

	// ------------------------------------------------------------
	// low trim registers, one per entry
	// ------------------------------------------------------------
	// upper-byte low registers
	generate
		for (genvar i = 0; i < 3; i++) begin : g_low
			assign low_wr[i] = I_REQ.wr_en && (I_REQ.addr == low_addr[i]);
			trim_low_byte_reg u_low (
				.i_clk(I_CLOCK),
				.i_rst(I_SYS_RST),
				.i_wr(low_wr[i]),
				.i_wdata(I_REQ.wdata),
				.o_rdata(low_rdata[i]),
				.o_byte(low_byte[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next values of full-word registers
	// ------------------------------------------------------------
	// halves of a split word update on separate writes, so the datapath
	// sees a mixed word between them; the host writes both halves
	always_comb begin
		ch6_gain_upper_word_d = ch6_gain_upper_word_q;
		ch7_setup_d = ch7_setup_q;
		ch7_offset_upper_word_d = ch7_offset_upper_word_q;
		ch7_gain_upper_word_d = ch7_gain_upper_word_q;
		if (I_REQ.wr_en) begin
			case (I_REQ.addr)
				calib_regs_pkg::CH6_GAIN_TRIM_HIGH_ADDR: begin
					ch6_gain_upper_word_d = I_REQ.wdata;
				end
				calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR: begin
					ch7_setup_d = I_REQ.wdata & calib_regs_pkg::SETUP_WRITE_MASK;
				end
				calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR: begin
					ch7_offset_upper_word_d = I_REQ.wdata;
				end
				calib_regs_pkg::CH7_GAIN_TRIM_HIGH_ADDR: begin
					ch7_gain_upper_word_d = I_REQ.wdata;
				end
				default: begin
					ch7_setup_d = ch7_setup_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read mux, registered
	// ------------------------------------------------------------
	// address is read every cycle; a write in the same cycle reads the old value
	always_comb begin
		rdata_d = 16'h0000;
		hit_d = 1'b1;
		case (I_REQ.addr)
			calib_regs_pkg::CH6_OFFSET_TRIM_LOW_ADDR: rdata_d = low_rdata[0];
			calib_regs_pkg::CH6_GAIN_TRIM_HIGH_ADDR: rdata_d = ch6_gain_upper_word_q;
			calib_regs_pkg::CH6_GAIN_TRIM_LOW_ADDR: rdata_d = low_rdata[1];
			calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR: rdata_d = ch7_setup_q;
			calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR: rdata_d = ch7_offset_upper_word_q;
			calib_regs_pkg::CH7_OFFSET_TRIM_LOW_ADDR: rdata_d = low_rdata[2];
			calib_regs_pkg::CH7_GAIN_TRIM_HIGH_ADDR: rdata_d = ch7_gain_upper_word_q;
			default: hit_d = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// reset values
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ch6_gain_upper_word_q <= calib_regs_pkg::GAIN_HIGH_RESET;
			ch7_setup_q <= calib_regs_pkg::ZERO_RESET;
			ch7_offset_upper_word_q <= calib_regs_pkg::ZERO_RESET;
			ch7_gain_upper_word_q <= calib_regs_pkg::GAIN_HIGH_RESET;
			rdata_q <= calib_regs_pkg::ZERO_RESET;
			hit_q <= 1'b0;
		end else begin
			ch6_gain_upper_word_q <= ch6_gain_upper_word_d;
			ch7_setup_q <= ch7_setup_d;
			ch7_offset_upper_word_q <= ch7_offset_upper_word_d;
			ch7_gain_upper_word_q <= ch7_gain_upper_word_d;
			rdata_q <= rdata_d;
			hit_q <= hit_d;
		end
	end

	assign O_RDATA = rdata_q;
	assign O_ADDR_HIT = hit_q;

	// ------------------------------------------------------------
	// datapath outputs
	// ------------------------------------------------------------
	// offset low byte, upper part held elsewhere
	assign O_CH6_OFFSET_LOW_BYTE_WORD = {16'h0000, low_byte[0]};
	assign O_CH6_GAIN = {ch6_gain_upper_word_q, low_byte[1]};
	assign O_CH7_OFFSET = {ch7_offset_upper_word_q, low_byte[2]};
	// channel 7 gain low byte lives outside this bank
	assign O_CH7_GAIN_UPPER = {ch7_gain_upper_word_q, 8'h00};
	assign O_CH7_SETUP.phase_delay =
		ch7_setup_q[calib_regs_pkg::PHASE_MSB:calib_regs_pkg::PHASE_LSB];
	assign O_CH7_SETUP.dc_removal_off = ch7_setup_q[calib_regs_pkg::DC_OFF_BIT];
	assign O_CH7_SETUP.input_select = calib_regs_pkg::input_sel_e'(
		ch7_setup_q[calib_regs_pkg::MUX_MSB:calib_regs_pkg::MUX_LSB]);
	assign O_CH7_DC_REMOVAL_EN =
		I_GLOBAL_DC_REMOVAL_SETTING && !ch7_setup_q[calib_regs_pkg::DC_OFF_BIT];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);

	a_setup_resv_zero: assert property (ch7_setup_q[5:3] == 3'b000)
		else $error("setup reserved bits not zero");
	a_setup_write: assert property (I_REQ.wr_en && I_REQ.addr == 6'h2c
		|=> ch7_setup_q == ($past(I_REQ.wdata) & 16'hffc7)) else $error("setup write wrong");
	a_dc_disable: assert property (ch7_setup_q[2] |-> !O_CH7_DC_REMOVAL_EN)
		else $error("dc removal not disabled");
	a_dc_follow: assert property (!ch7_setup_q[2]
		|-> O_CH7_DC_REMOVAL_EN == I_GLOBAL_DC_REMOVAL_SETTING) else $error("dc not global");
	a_gain6_write: assert property (I_REQ.wr_en && I_REQ.addr == 6'h2a
		|=> O_CH6_GAIN[23:8] == $past(I_REQ.wdata)) else $error("ch6 gain not written");
	a_offset7_sign: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR
		|=> (O_CH7_OFFSET < 0) == $past(I_REQ.wdata[15]))
		else $error("offset sign wrong");
	a_read_low: assert property (!I_REQ.wr_en && I_REQ.addr == 6'h2e
		|=> O_RDATA[7:0] == 8'h00 && O_RDATA[15:8] == low_byte[2]) else $error("low read wrong");
	a_phase_field: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR
		|=> O_CH7_SETUP.phase_delay == $past(I_REQ.wdata[15:6]))
		else $error("phase field wrong");
	a_mux_field: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR
		|=> O_CH7_SETUP.input_select == $past(I_REQ.wdata[1:0]))
		else $error("input select wrong");
	a_gain_low_byte: assert property (I_REQ.wr_en && I_REQ.addr == 6'h2b
		|=> O_CH6_GAIN[7:0] == $past(I_REQ.wdata[15:8])) else $error("gain low wrong");
	a_unmapped: assert property (I_REQ.addr == 6'h00 |=> !O_ADDR_HIT && O_RDATA == 16'h0000)
		else $error("unmapped read wrong");
	a_first_gain: assert property ($fell(I_SYS_RST) |-> ch6_gain_upper_word_q == 16'h8000
		&& ch7_gain_upper_word_q == 16'h8000 && low_byte[1] == 8'h00) else $error("gain reset");

	c_setup_write: cover property (I_REQ.wr_en && I_REQ.addr == 6'h2c);
	c_test_neg: cover property (O_CH7_SETUP.input_select == calib_regs_pkg::INPUT_TEST_NEG);
	c_neg_offset: cover property (O_CH7_OFFSET[23]);
	c_read_gain7: cover property (!I_REQ.wr_en && I_REQ.addr == 6'h2f);
	c_dc_override: cover property (I_GLOBAL_DC_REMOVAL_SETTING && ch7_setup_q[calib_regs_pkg::DC_OFF_BIT]);

	// ------------------------------------------------------------
	// write paths of the split words and the setup dc off bit
	// ------------------------------------------------------------
	a_offset6_low: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH6_OFFSET_TRIM_LOW_ADDR
		|=> O_CH6_OFFSET_LOW_BYTE_WORD == {16'h0000, $past(I_REQ.wdata[15:8])})
		else $error("ch6 offset low wrong");
	a_offset7_write: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR
		|=> O_CH7_OFFSET[23:8] == $past(I_REQ.wdata))
		else $error("ch7 offset upper wrong");
	a_dc_write: assert property (
		I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR
		|=> O_CH7_SETUP.dc_removal_off == $past(I_REQ.wdata[2]))
		else $error("dc off bit wrong");

	// ------------------------------------------------------------
	// values held between writes
	// ------------------------------------------------------------
	// a write to a neighbour must not disturb these words
	a_gain_hold: assert property (
		!(I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH6_GAIN_TRIM_HIGH_ADDR)
		|=> $stable(ch6_gain_upper_word_q))
		else $error("ch6 gain changed without write");
	a_gain7_hold: assert property (
		!(I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_GAIN_TRIM_HIGH_ADDR)
		|=> $stable(ch7_gain_upper_word_q))
		else $error("ch7 gain changed without write");
	a_setup_hold: assert property (
		!(I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR)
		|=> $stable(ch7_setup_q))
		else $error("setup changed without write");
	a_offset7_hold: assert property (
		!(I_REQ.wr_en && I_REQ.addr == calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR)
		|=> $stable(ch7_offset_upper_word_q))
		else $error("ch7 offset changed without write");

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	a_gain6_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH6_GAIN_TRIM_HIGH_ADDR
		|=> O_RDATA == $past(ch6_gain_upper_word_q))
		else $error("ch6 gain read wrong");
	a_offset7_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH7_OFFSET_TRIM_HIGH_ADDR
		|=> O_RDATA == $past(ch7_offset_upper_word_q))
		else $error("ch7 offset read wrong");
	a_gain6_low_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH6_GAIN_TRIM_LOW_ADDR
		|=> O_RDATA == {$past(O_CH6_GAIN[7:0]), 8'h00})
		else $error("ch6 gain low read wrong");
	a_offset6_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH6_OFFSET_TRIM_LOW_ADDR
		|=> O_RDATA == {$past(O_CH6_OFFSET_LOW_BYTE_WORD[7:0]), 8'h00})
		else $error("ch6 offset low read wrong");
	a_low_resv_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH6_OFFSET_TRIM_LOW_ADDR
		|| I_REQ.addr == calib_regs_pkg::CH6_GAIN_TRIM_LOW_ADDR
		|=> O_RDATA[7:0] == 8'h00) else $error("low read not zero");
	a_setup_read: assert property (
		I_REQ.addr == calib_regs_pkg::CH7_CHANNEL_SETUP_ADDR
		|=> O_RDATA[5:3] == 3'b000)
		else $error("setup reserved read not zero");

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	// seen at the first edge after every release, mid-run resets too
	a_reset_setup: assert property ($fell(I_SYS_RST) |->
		ch7_setup_q == calib_regs_pkg::ZERO_RESET) else $error("setup reset wrong");
	a_reset_offset7: assert property ($fell(I_SYS_RST) |->
		O_CH7_OFFSET == 24'sh000000) else $error("ch7 offset reset wrong");
	a_reset_gain_low: assert property ($fell(I_SYS_RST) |->
		O_CH6_GAIN[7:0] == calib_regs_pkg::LOW_BYTE_RESET) else $error("gain low reset wrong");

endmodule

// File: include/calib_regs_pkg.sv
// package: register map, field layout and reset values of the channel 6/7 calibration bank
package calib_regs_pkg;

	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] CH6_OFFSET_TRIM_LOW_ADDR = 6'h29;
	localparam logic [5:0] CH6_GAIN_TRIM_HIGH_ADDR = 6'h2a;
	localparam logic [5:0] CH6_GAIN_TRIM_LOW_ADDR = 6'h2b;
	localparam logic [5:0] CH7_CHANNEL_SETUP_ADDR = 6'h2c;
	localparam logic [5:0] CH7_OFFSET_TRIM_HIGH_ADDR = 6'h2d;
	localparam logic [5:0] CH7_OFFSET_TRIM_LOW_ADDR = 6'h2e;
	localparam logic [5:0] CH7_GAIN_TRIM_HIGH_ADDR = 6'h2f;

	// ------------------------------------------------------------
	// reset values and field positions
	// ------------------------------------------------------------
	localparam logic [15:0] GAIN_HIGH_RESET = 16'h8000;
	localparam logic [15:0] ZERO_RESET = 16'h0000;
	localparam logic [7:0] LOW_BYTE_RESET = 8'h00;
	localparam int LOW_BYTE_MSB = 15;
	localparam int LOW_BYTE_LSB = 8;
	localparam int PHASE_MSB = 15;
	localparam int PHASE_LSB = 6;
	localparam int DC_OFF_BIT = 2;
	localparam int MUX_MSB = 1;
	localparam int MUX_LSB = 0;
	localparam logic [15:0] SETUP_WRITE_MASK = 16'hffc7;

	// ------------------------------------------------------------
	// input selection codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		INPUT_PINS = 2'b00,
		INPUT_SHORTED = 2'b01,
		INPUT_TEST_POS = 2'b10,
		INPUT_TEST_NEG = 2'b11
	} input_sel_e;

	// ------------------------------------------------------------
	// register access request and decoded channel 7 setup
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr_en;
		logic [5:0] addr;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic signed [9:0] phase_delay;
		logic dc_removal_off;
		input_sel_e input_select;
	} ch_setup_s;

endpackage

// File: core/trim_low_byte_reg.sv
// module: low-byte trim register with a read-only zero lower byte
`timescale 1ns/100ps
module trim_low_byte_reg (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// write side
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	// register view
	output logic [15:0] o_rdata,
	output logic [7:0] o_byte
);

	logic [7:0] byte_q;
	logic [7:0] byte_d;

	// ------------------------------------------------------------
	// next value: only the upper write byte is taken
	// ------------------------------------------------------------
	// lower write byte dropped
	always_comb begin
		byte_d = byte_q;
		if (i_wr) begin
			byte_d = i_wdata[calib_regs_pkg::LOW_BYTE_MSB:calib_regs_pkg::LOW_BYTE_LSB];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			byte_q <= calib_regs_pkg::LOW_BYTE_RESET;
		end else begin
			byte_q <= byte_d;
		end
	end

	assign o_rdata = {byte_q, 8'h00};
	assign o_byte = byte_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_low_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rdata[7:0] == 8'h00) else $error("low byte not zero");
	a_byte_load: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr |=> o_rdata[15:8] == $past(i_wdata[15:8])) else $error("upper byte not loaded");

endmodule

// File: verification/host_port_model.sv
// file: host controller model issuing register requests to the calibration bank
`timescale 1ns/100ps
module host_port_model (
	// clock
	input wire logic i_clk,
	// request out, answer back
	output calib_regs_pkg::reg_req_s o_req,
	input wire logic [15:0] i_rdata,
	input wire logic i_hit
);
	// ----------------
	// bus cycles
	// ----------------
	// idle request from time zero
	initial begin
		o_req = '0;
	end

	// write held for one taking edge, then write data scrambled so nothing stale lingers
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_req <= '{wr_en: 1'b1, addr: a, wdata: d};
		@(posedge i_clk);
		o_req.wr_en <= 1'b0;
		o_req.wdata <= ~d;
	endtask

	// read: address taken at the next edge, answer registered at that edge
	task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic h);
		@(posedge i_clk);
		o_req <= '{wr_en: 1'b0, addr: a, wdata: ~o_req.wdata};
		@(posedge i_clk);
		#1;
		d = i_rdata;
		h = i_hit;
	endtask
endmodule

// File: verification/tb_top.sv
// file: self-checking bench for the channel 6/7 calibration bank
`timescale 1ns/100ps
module tb_top;
	// ----------------
	// clock, reset and wiring
	// ----------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic dc_glob = 1'b0;
	int error_cnt = 0;
	int total_checks = 0;
	calib_regs_pkg::reg_req_s req;
	logic [15:0] rdata;
	logic hit;
	logic [23:0] ch6_off, ch6_gain, ch7_gain;
	logic signed [23:0] ch7_off;
	calib_regs_pkg::ch_setup_s setup;
	logic dc_en;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	adc_ch6_ch7_calib_config_regs uut (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_REQ(req), .O_RDATA(rdata), .O_ADDR_HIT(hit),
		.I_GLOBAL_DC_REMOVAL_SETTING(dc_glob), .O_CH6_OFFSET_LOW_BYTE_WORD(ch6_off),
		.O_CH6_GAIN(ch6_gain), .O_CH7_OFFSET(ch7_off), .O_CH7_GAIN_UPPER(ch7_gain),
		.O_CH7_SETUP(setup), .O_CH7_DC_REMOVAL_EN(dc_en)
	);

	host_port_model host (.i_clk(clk), .o_req(req), .i_rdata(rdata), .i_hit(hit));

	// ----------------
	// compare and verdict
	// ----------------
	task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// read one register and judge data and hit flag
	task automatic rd_chk(input logic [5:0] a, input logic [15:0] e, input logic eh);
		logic [15:0] d;
		logic h;
		host.rd(a, d, h);
		chk($sformatf("rdata at %h", a), {8'h00, d}, {8'h00, e});
		chk($sformatf("hit at %h", a), {23'h0, h}, {23'h0, eh});
	endtask

	// ----------------
	// scenarios
	// ----------------
	// reset values across the map plus both unmapped neighbours
	task automatic test_reset();
		logic [5:0] a;
		logic [15:0] e;
		for (int i = 32'h28; i <= 32'h30; i++) begin
			a = 6'(i);
			e = (a == 6'h2a || a == 6'h2f) ? 16'h8000 : 16'h0000;
			rd_chk(a, e, a inside {[6'h29:6'h2f]});
		end
		chk("ch6 offset", ch6_off, 24'h000000);
		chk("ch6 gain", ch6_gain, 24'h800000);
		chk("ch7 gain", ch7_gain, 24'h800000);
		chk("ch7 offset", ch7_off, 24'h000000);
		chk("ch7 setup", {11'h0, setup}, 24'h0);
		chk("dc enable", {23'h0, dc_en}, 24'h1);
	endtask

	// all ones everywhere: reserved bits must stay zero
	task automatic test_masks();
		logic [5:0] a;
		logic [15:0] e;
		for (int i = 'h28; i <= 'h30; i++) begin
			a = 6'(i);
			host.wr(a, 16'hffff);
			case (a)
				6'h29, 6'h2b, 6'h2e: e = 16'hff00;
				6'h2c: e = 16'hffc7;
				6'h2a, 6'h2d, 6'h2f: e = 16'hffff;
				default: e = 16'h0000;
			endcase
			rd_chk(a, e, a inside {[6'h29:6'h2f]});
		end
	endtask

	// split words reassembled on the datapath outputs
	task automatic test_words();
		host.wr(6'h29, 16'h9a55);
		host.wr(6'h2a, 16'h1234);
		host.wr(6'h2b, 16'h56ab);
		host.wr(6'h2d, 16'hfedc);
		host.wr(6'h2e, 16'hba01);
		host.wr(6'h2f, 16'h4321);
		#1;
		chk("ch6 offset word", ch6_off, 24'h00009a);
		chk("ch6 gain word", ch6_gain, 24'h123456);
		chk("ch7 offset word", ch7_off, 24'hfedcba);
		chk("ch7 offset sign", {23'h0, ch7_off < 0}, 24'h1);
		chk("ch7 gain word", ch7_gain, 24'h432100);
	endtask

	// every input code, both dc bits, both global levels, negative phase near the limit
	task automatic test_setup();
		logic [9:0] ph;
		logic [15:0] w;
		for (int i = 0; i < 8; i++) begin
			ph = 10'h200 + 10'(i);
			w = {ph, 3'b101, 3'(i)};
			host.wr(6'h2c, w);
			dc_glob <= i[0];
			#1;
			chk("phase", {14'h0, setup.phase_delay}, {14'h0, ph});
			chk("dc off", {23'h0, setup.dc_removal_off}, {23'h0, w[2]});
			chk("input select", {22'h0, setup.input_select}, {22'h0, w[1:0]});
			chk("dc enable", {23'h0, dc_en}, {23'h0, i[0] & ~w[2]});
			rd_chk(6'h2c, w & 16'hffc7, 1'b1);
		end
	endtask

	// reset raised mid-run after every register was written, then the map read again
	task automatic test_reset_again();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_reset();
	endtask

	// ----------------
	// main sequence and watchdog
	// ----------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		dc_glob <= 1'b1;
		test_reset();
		test_masks();
		test_words();
		test_setup();
		test_reset_again();
		give_verdict();
	end

	// hang guard, far beyond the 124 or so cycles the run needs
	initial begin
		#(20000 * 5);
		error_cnt++;
		give_verdict();
	end
endmodule
